//--- common/fwc_pkg.sv
// fwc_pkg: constants for the flash writer command port
// assumes a 125 MHz system clock; times are converted to cycles here
package fwc_pkg;
    localparam int unsigned CLK_MHZ          = 125;
    // power-on waits, in ms as printed
    localparam int unsigned OSC_STAB_MS      = 40;
    localparam int unsigned SETUP_MS         = 10;
    localparam int unsigned OSC_STAB_CYC     = OSC_STAB_MS * 1000 * CLK_MHZ;
    localparam int unsigned SETUP_CYC        = SETUP_MS * 1000 * CLK_MHZ;
    // command codes
    localparam logic [7:0]  CMD_READ         = 8'h00;
    localparam logic [7:0]  CMD_PROGRAM      = 8'h40;
    localparam logic [7:0]  CMD_ERASE        = 8'h20;
    localparam logic [7:0]  CMD_STATUS       = 8'h71;
    localparam logic [7:0]  FILL_BYTE        = 8'hff;
    localparam logic [7:0]  BLK_LOW_A        = 8'h00;
    localparam logic [7:0]  BLK_LOW_B        = 8'h80;
    // return code bit positions
    localparam int unsigned RC_ABNORMAL      = 7;
    localparam int unsigned RC_CMD_ERR       = 6;
    localparam int unsigned RC_PROG_ERR      = 5;
    localparam int unsigned RC_ERASE_ERR     = 4;
    localparam int unsigned RC_COUNT_ERR     = 1;
    localparam int unsigned RC_ADDR_ERR      = 0;
    localparam logic [7:0]  RC_RESET         = 8'h00;
    // array operation duration defaults (cycles, kept short-able via parameters)
    localparam int unsigned PROG_CYC_DEF     = 1000;
    localparam int unsigned ERASE_CYC_DEF    = 4000;
    typedef enum logic [3:0] {
        FWC_ST_OSC, FWC_ST_SETUP, FWC_ST_READ, FWC_ST_WAIT, FWC_ST_PGM_ADDR,
        FWC_ST_PGM_DATA, FWC_ST_PGM_BUSY, FWC_ST_ERS_2ND, FWC_ST_ERS_BUSY,
        FWC_ST_STS_2ND, FWC_ST_STATUS, FWC_ST_POLL
    } fwc_state_e;
endpackage

//--- dv/fwc_array_model.sv
// fwc_array_model: behavioural flash array behind the command port
// assumes one-cycle start pulses and a block buffer read with 1-cycle latency
`timescale 1ns/1ps
module fwc_array_model #(
    parameter int PROG_CYC  = 200,
    parameter int ERASE_CYC = 300
) (
    input  wire logic        clock,
    input  wire logic        fail_mode,
    input  wire logic        arr_prog_start,
    input  wire logic        arr_erase_start,
    input  wire logic [15:0] arr_addr,
    input  wire logic [7:0]  pbuf_rd_data,
    output logic      [6:0]  pbuf_rd_addr,
    output logic      [7:0]  arr_rd_data,
    output logic             arr_done,
    output logic             arr_fail,
    output logic             arr_count_over
);
    logic [7:0]  mem [0:65535];
    logic [15:0] base;
    assign arr_rd_data = mem[arr_addr];
    // outputs change at the falling edge so the port samples them settled
    task finish_op(input int cyc);
        repeat (cyc) @(negedge clock);
        arr_fail = fail_mode;
        arr_count_over = fail_mode;
        arr_done = 1'b1;
        @(negedge clock);
        arr_done = 1'b0;
    endtask
    initial begin
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'hff;
        pbuf_rd_addr   = 7'h00;
        arr_done       = 1'b0;
        arr_fail       = 1'b0;
        arr_count_over = 1'b0;
        forever begin
            @(negedge clock);
            if (arr_prog_start === 1'b1) begin
                base = arr_addr;
                for (int i = 0; i < 128; i++) begin
                    pbuf_rd_addr = i[6:0];
                    @(negedge clock);
                    mem[base + 16'(i)] = pbuf_rd_data;
                end
                finish_op(PROG_CYC);
            end else if (arr_erase_start === 1'b1) begin
                for (int i = 0; i < 65536; i++)
                    mem[i] = 8'hff;
                finish_op(ERASE_CYC);
            end
        end
    end
endmodule

//--- dv/fwc_cmd_port_tb.sv
// fwc_cmd_port_tb: programmer-side bench for the writer-mode command port
// assumes short start-up waits and the behavioural array model
`timescale 1ns/1ps
module fwc_cmd_port_tb;
    import fwc_pkg::*;
    logic        clock, rstn, ce_n, oe_n, we_n, pve, fail_mode;
    logic [15:0] addr, arr_addr;
    logic [7:0]  din, dout, pbuf_rd_data, arr_rd_data, d;
    logic        dout_oe, end_flag, out_flag, prog_start, erase_start;
    logic        arr_done, arr_fail, arr_count_over;
    logic [6:0]  pbuf_rd_addr;
    int          fail_count, total_checks, erase_cnt;
    always #4 clock = ~clock;
    always @(posedge clock) if (erase_start === 1'b1) erase_cnt++;
    fwc_cmd_port #(.OSC_CYC(20), .SETUP_CY(20)) fwc_cmd_port_i (
        .clock(clock), .rstn(rstn), .chip_sel_n(ce_n), .out_en_n(oe_n), .wr_en_n(we_n),
        .program_voltage_enable(pve), .array_address_lines(addr), .byte_data_in(din),
        .byte_data_lines(dout), .byte_data_oe(dout_oe), .end_status_flag_line(end_flag),
        .outcome_flag_line(out_flag), .arr_prog_start(prog_start),
        .arr_erase_start(erase_start), .arr_addr(arr_addr), .pbuf_rd_data(pbuf_rd_data),
        .pbuf_rd_addr(pbuf_rd_addr), .arr_rd_data(arr_rd_data), .arr_done(arr_done),
        .arr_fail(arr_fail), .arr_count_over(arr_count_over));
    fwc_array_model fwc_array_model_i (
        .clock(clock), .fail_mode(fail_mode), .arr_prog_start(prog_start),
        .arr_erase_start(erase_start), .arr_addr(arr_addr), .pbuf_rd_data(pbuf_rd_data),
        .pbuf_rd_addr(pbuf_rd_addr), .arr_rd_data(arr_rd_data), .arr_done(arr_done),
        .arr_fail(arr_fail), .arr_count_over(arr_count_over));
    task results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // released lines show the inverse so stale values never pass
    task cmd(input logic [7:0] v, input logic [15:0] a = 16'h0000);
        @(negedge clock);
        ce_n = 1'b0;
        addr = a;
        din  = v;
        we_n = 1'b0;
        repeat (3) @(negedge clock);
        we_n = 1'b1;
        repeat (5) @(negedge clock);
        ce_n = 1'b1;
        addr = ~a;
        din  = ~v;
        repeat (8) @(negedge clock);
    endtask
    task rd(input logic [15:0] a, output logic [7:0] v);
        @(negedge clock);
        ce_n = 1'b0;
        oe_n = 1'b0;
        addr = a;
        repeat (8) @(negedge clock);
        v = dout;
        chk({7'h00, dout_oe}, 8'h01, "output enable");
        ce_n = 1'b1;
        oe_n = 1'b1;
        addr = ~a;
        repeat (4) @(negedge clock);
    endtask
    // bounded wait, reads only while busy
    task poll(input logic [7:0] exp);
        int n;
        n = 0;
        do begin
            rd(16'h0000, d);
            n++;
        end while (d[7] !== 1'b1 && n < 200);
        if (d[7] !== 1'b1) begin
            fail_count++;
            $display("ERROR t=%0t no end indication", $time);
            results();
        end
        chk(d, exp, "polling byte");
        chk({6'h00, end_flag, out_flag}, exp >> 6, "polling lines");
    endtask
    task sts(input logic [7:0] exp);
        cmd(CMD_STATUS);
        cmd(CMD_STATUS);
        rd(16'h0000, d);
        chk(d, exp, "return code");
        rd(16'h0040, d);
        chk(d, exp, "return code held");
    endtask
    // block of 128, address only in cycle two
    // later cycles carry a wrong address, so a late capture lands the block elsewhere
    task prog(input logic [15:0] base);
        cmd(CMD_PROGRAM);
        for (int k = 0; k < 128; k++)
            cmd(k < 64 ? 8'(k) ^ 8'h5a : FILL_BYTE, k == 0 ? base : ~base);
        repeat (20) @(negedge clock);
    endtask
    // polling start wait is scaled down like the start-up waits
    task erase();
        cmd(CMD_ERASE);
        cmd(CMD_ERASE);
        repeat (20) @(negedge clock);
    endtask
    initial begin
        {clock, rstn, pve, fail_mode} = 4'b0010;
        {ce_n, oe_n, we_n} = 3'b111;
        addr = 16'h0000;
        din = 8'h00;
        {fail_count, total_checks, erase_cnt} = '0;
        repeat (20) @(negedge clock);
        rstn = 1'b1;
        cmd(CMD_ERASE);
        cmd(CMD_ERASE);
        repeat (30) @(negedge clock);
        rd(16'h0100, d);
        chk(d, 8'hff, "start-up read");
        chk(8'(erase_cnt), 8'h00, "erase during start-up");
        prog(16'h0100);
        rd(16'h0000, d);
        chk(d, 8'h00, "busy polling");
        poll(8'hc0);
        rd(16'h0000, d);
        chk(d, 8'hc0, "polling held");
        sts(8'h00);
        cmd(CMD_READ);
        for (int k = 60; k < 68; k++) begin
            rd(16'h0100 + 16'(k), d);
            chk(d, k < 64 ? 8'(k) ^ 8'h5a : FILL_BYTE, "array byte");
        end
        prog(16'h0210);
        poll(8'h80);
        // misaligned block ends abnormal with programming and address error bits
        sts(8'ha1);
        erase();
        poll(8'hc0);
        cmd(CMD_READ);
        rd(16'h0101, d);
        chk(d, 8'hff, "erased byte");
        fail_mode = 1'b1;
        erase();
        poll(8'h80);
        sts(8'h92);
        fail_mode = 1'b0;
        cmd(8'h33);
        sts(8'hc0);
        cmd(CMD_ERASE);
        pve = 1'b0;
        cmd(CMD_ERASE);
        pve = 1'b1;
        sts(8'hc0);
        chk(8'(erase_cnt), 8'h02, "erase starts");
        results();
    end
    initial begin
        repeat (100000) @(posedge clock);
        fail_count++;
        results();
    end
endmodule

//--- hdl/fwc_cmd_port.sv
// fwc_cmd_port: writer-mode command sequencer of the on-chip flash
// assumes programmer pins arrive asynchronously; array engine is a simple handshake
// Function
// - after program, erase or status read the device waits for a command
// - memory read mode accepts commands like the command wait state
// - memory read serves any number of reads without new commands
// - after power-on the device lands in memory read mode
// - commands ignored during 40 ms and 10 ms start-up waits
// - block address low byte not 00 or 80 still writes but flags error
// - block address captured only in the second command cycle
// - polling flags hold until next command, readable with ce and oe
// - erase always clears the whole array
// - return code holds until a non-status command arrives
// - return code resets to zero; bits give abnormal end and error kinds
// - polling outputs busy 00, abnormal end 10, normal end 11, rest zero
// - codes: 00 read, 40 program, 20 twice erase, 71 twice status
`timescale 1ns/1ps
module fwc_cmd_port
    import fwc_pkg::*;
#(
    parameter int unsigned OSC_CYC   = OSC_STAB_CYC,
    parameter int unsigned SETUP_CY  = SETUP_CYC,
    parameter int          BLK_BYTES = 128,
    parameter int          AW        = 16
) (
    input  wire logic          clock,
    input  wire logic          rstn,
    input  wire logic          chip_sel_n,
    input  wire logic          out_en_n,
    input  wire logic          wr_en_n,
    input  wire logic          program_voltage_enable,
    input  wire logic [AW-1:0] array_address_lines,
    input  wire logic [7:0]    byte_data_in,
    output logic      [7:0]    byte_data_lines,
    output logic               byte_data_oe,
    output logic               end_status_flag_line,
    output logic               outcome_flag_line,
    // array engine side
    output logic               arr_prog_start,
    output logic               arr_erase_start,
    output logic      [AW-1:0] arr_addr,
    output logic      [7:0]    pbuf_rd_data,
    input  wire logic [6:0]    pbuf_rd_addr,
    input  wire logic [7:0]    arr_rd_data,
    input  wire logic          arr_done,
    input  wire logic          arr_fail,
    input  wire logic          arr_count_over
);
    default clocking fwc_cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // three-stage sync on control pins, two stages on data and address; a level counts once stages two and three agree
    logic [2:0] ce_s, oe_s, we_s, pve_s;
    logic [7:0] d_s1, d_s2;
    logic [AW-1:0] a_s1, a_s2;
    logic we_prev_reg, we_prev_next;
    always_ff @(posedge clock) begin
        ce_s <= {ce_s[1:0], chip_sel_n};
        oe_s <= {oe_s[1:0], out_en_n};
        we_s <= {we_s[1:0], wr_en_n};
        pve_s <= {pve_s[1:0], program_voltage_enable};
        d_s1 <= byte_data_in;
        d_s2 <= d_s1;
        a_s1 <= array_address_lines;
        a_s2 <= a_s1;
    end
    wire logic ce_lo = !ce_s[1] && !ce_s[2];
    wire logic oe_lo = !oe_s[1] && !oe_s[2];
    wire logic we_hi = we_s[1] && we_s[2];
    wire logic we_lo = !we_s[1] && !we_s[2];
    // write strobe taken at the rising edge of write enable
    wire logic wr_stb = ce_lo && we_hi && !we_prev_reg;

    fwc_state_e st_reg, st_next;
    logic [22:0] cnt_reg, cnt_next;
    logic [7:0]  blk_reg, blk_next;
    logic [7:0]  rc_reg, rc_next;
    logic [1:0]  poll_reg, poll_next;
    logic [AW-1:0] addr_reg, addr_next;
    logic        pgo_reg, pgo_next, ego_reg, ego_next;

    always_comb begin
        st_next      = st_reg;
        cnt_next     = cnt_reg;
        blk_next     = blk_reg;
        rc_next      = rc_reg;
        poll_next    = poll_reg;
        addr_next    = addr_reg;
        pgo_next     = 1'b0;
        ego_next     = 1'b0;
        we_prev_next = we_lo ? 1'b0 : (we_hi ? 1'b1 : we_prev_reg);
        case (st_reg)
            FWC_ST_OSC: begin
                cnt_next = cnt_reg + 23'h1;
                if (cnt_reg >= 23'(OSC_CYC - 1)) begin
                    cnt_next = '0;
                    st_next  = FWC_ST_SETUP;
                end
            end
            FWC_ST_SETUP: begin
                cnt_next = cnt_reg + 23'h1;
                if (cnt_reg >= 23'(SETUP_CY - 1)) begin
                    cnt_next = '0;
                    st_next  = FWC_ST_READ;
                end
            end
            FWC_ST_READ, FWC_ST_WAIT, FWC_ST_STATUS, FWC_ST_POLL: begin
                if (wr_stb) begin
                    // polling flags cleared by any write
                    poll_next = 2'b00;
                    // return code cleared only by non-status
                    if (d_s2 != CMD_STATUS) begin
                        rc_next = RC_RESET;
                    end
                    case (d_s2)
                        CMD_READ:    st_next = FWC_ST_READ;
                        CMD_PROGRAM: st_next = FWC_ST_PGM_ADDR;
                        CMD_ERASE:   st_next = FWC_ST_ERS_2ND;
                        CMD_STATUS:  st_next = FWC_ST_STS_2ND;
                        default: begin
                            rc_next[RC_ABNORMAL] = 1'b1;
                            rc_next[RC_CMD_ERR]  = 1'b1;
                            st_next              = FWC_ST_WAIT;
                        end
                    endcase
                end
            end
            FWC_ST_PGM_ADDR: begin
                if (wr_stb) begin
                    addr_next = a_s2;
                    if (a_s2[7:0] != BLK_LOW_A && a_s2[7:0] != BLK_LOW_B) begin
                        rc_next[RC_ABNORMAL] = 1'b1;
                        rc_next[RC_ADDR_ERR] = 1'b1;
                    end
                    blk_next = 8'h1;
                    st_next  = (BLK_BYTES == 1) ? FWC_ST_PGM_BUSY : FWC_ST_PGM_DATA;
                    pgo_next = (BLK_BYTES == 1);
                end
            end
            FWC_ST_PGM_DATA: begin
                if (wr_stb) begin
                    blk_next = blk_reg + 8'h1;
                    if (blk_reg == 8'(BLK_BYTES - 1)) begin
                        st_next  = FWC_ST_PGM_BUSY;
                        pgo_next = 1'b1;
                    end
                end
            end
            FWC_ST_ERS_2ND, FWC_ST_STS_2ND: begin
                if (wr_stb) begin
                    if (d_s2 == st_cmd(st_reg) && (st_reg == FWC_ST_STS_2ND ||
                            (pve_s[1] && pve_s[2]))) begin
                        ego_next = (st_reg == FWC_ST_ERS_2ND);
                        st_next  = (st_reg == FWC_ST_ERS_2ND) ? FWC_ST_ERS_BUSY
                                                               : FWC_ST_STATUS;
                    end else begin
                        rc_next[RC_ABNORMAL] = 1'b1;
                        rc_next[RC_CMD_ERR]  = 1'b1;
                        st_next              = FWC_ST_WAIT;
                    end
                end
            end
            FWC_ST_PGM_BUSY, FWC_ST_ERS_BUSY: begin
                poll_next = 2'b00;
                if (arr_done) begin
                    if (arr_fail || rc_reg[RC_ABNORMAL]) begin
                        rc_next[RC_ABNORMAL] = 1'b1;
                        rc_next[RC_PROG_ERR] = rc_reg[RC_PROG_ERR] || (st_reg == FWC_ST_PGM_BUSY);
                        rc_next[RC_ERASE_ERR] = (st_reg == FWC_ST_ERS_BUSY);
                        rc_next[RC_COUNT_ERR] = arr_count_over;
                        poll_next = 2'b10;
                    end else begin
                        poll_next = 2'b11;
                    end
                    st_next = FWC_ST_POLL;
                end
            end
            default: st_next = FWC_ST_WAIT;
        endcase
    end

    function automatic logic [7:0] st_cmd(input fwc_state_e s);
        st_cmd = (s == FWC_ST_ERS_2ND) ? CMD_ERASE : CMD_STATUS;
    endfunction

    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_reg      <= FWC_ST_OSC;
            cnt_reg     <= '0;
            blk_reg     <= '0;
            rc_reg      <= RC_RESET;
            poll_reg    <= 2'b00;
            addr_reg    <= '0;
            pgo_reg     <= 1'b0;
            ego_reg     <= 1'b0;
            we_prev_reg <= 1'b1;
        end else begin
            st_reg      <= st_next;
            cnt_reg     <= cnt_next;
            blk_reg     <= blk_next;
            rc_reg      <= rc_next;
            poll_reg    <= poll_next;
            addr_reg    <= addr_next;
            pgo_reg     <= pgo_next;
            ego_reg     <= ego_next;
            we_prev_reg <= we_prev_next;
        end
    end

    // data byte k lands at index k; byte 0 is the address cycle's data
    fwc_page_buf #(.DEPTH(BLK_BYTES), .AW(7)) u_buf (
        .clock   (clock),
        .wr_en   (wr_stb && (st_reg == FWC_ST_PGM_ADDR || st_reg == FWC_ST_PGM_DATA)),
        .wr_addr ((st_reg == FWC_ST_PGM_ADDR) ? 7'h00 : blk_reg[6:0]),
        .wr_data (d_s2),
        .rd_addr (pbuf_rd_addr),
        .rd_data (pbuf_rd_data)
    );

    assign arr_prog_start  = pgo_reg;
    assign arr_erase_start = ego_reg;
    // read address follows the pins in read mode; block address otherwise
    assign arr_addr        = (st_reg == FWC_ST_READ) ? a_s2 : addr_reg;

    logic [7:0] dout_reg, dout_next;
    always_comb begin
        // reads repeat freely in read mode
        if (st_reg == FWC_ST_READ) begin
            dout_next = arr_rd_data;
        end else if (st_reg == FWC_ST_STATUS) begin
            // return code, undefined bits read zero
            dout_next = rc_reg & 8'hf3;
        end else begin
            dout_next = {poll_reg, 6'h00};
        end
    end
    always_ff @(posedge clock) begin
        if (!rstn) begin
            dout_reg <= 8'h00;
        end else begin
            dout_reg <= dout_next;
        end
    end

    assign byte_data_lines      = dout_reg;
    assign byte_data_oe         = ce_lo && oe_lo && we_hi;
    assign end_status_flag_line = poll_reg[1];
    assign outcome_flag_line    = poll_reg[0];

    sequence s_busy;
        st_reg inside {FWC_ST_PGM_BUSY, FWC_ST_ERS_BUSY};
    endsequence
    sequence s_op_done;
        s_busy ##0 arr_done;
    endsequence
    property p_boot_quiet;
        (st_reg inside {FWC_ST_OSC, FWC_ST_SETUP}) |=> !arr_erase_start && !arr_prog_start;
    endproperty
    a_boot_quiet: assert property (p_boot_quiet) else $error("boot write");
    property p_poll_hold;
        (st_reg == FWC_ST_POLL && !wr_stb) |=> $stable(poll_reg);
    endproperty
    a_poll_hold: assert property (p_poll_hold) else $error("poll moved");
    property p_rc_hold;
        (st_reg == FWC_ST_STATUS && !(wr_stb && d_s2 != CMD_STATUS)) |=> $stable(rc_reg);
    endproperty
    a_rc_hold: assert property (p_rc_hold) else $error("rc moved");
    property p_op_end;
        s_op_done |=> st_reg == FWC_ST_POLL && end_status_flag_line;
    endproperty
    a_op_end: assert property (p_op_end) else $error("no end flag");
    property p_addr_err;
        (st_reg == FWC_ST_PGM_ADDR && wr_stb && a_s2[6:0] != 7'h00) |=> rc_reg[RC_ADDR_ERR];
    endproperty
    a_addr_err: assert property (p_addr_err) else $error("no address error");
    property p_blk_go;
        (st_reg == FWC_ST_PGM_DATA && wr_stb && blk_reg == 8'(BLK_BYTES - 1)) |=> arr_prog_start;
    endproperty
    a_blk_go: assert property (p_blk_go) else $error("no program start");
endmodule

//--- hdl/fwc_page_buf.sv
// fwc_page_buf: one block of program data, one write and one read port
// assumes single clock; read data registered
`timescale 1ns/1ps
module fwc_page_buf #(
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    input  wire logic          clock,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
